//--- core/phsc_map.svh
// Register offsets, field positions, fixed values and reset values of the header bank.
`ifndef PHSC_MAP_SVH
`define PHSC_MAP_SVH

`define PHSC_OFF_CLASS      12'h008
`define PHSC_OFF_INFO       12'h00C
`define PHSC_OFF_BASE_PRI   12'h010
`define PHSC_OFF_BASE_ALT   12'h014
`define PHSC_OFF_SC_CTL     12'h170
`define PHSC_OFF_SC_ADDR    12'h174

`define PHSC_CLASS_BASE     8'h06
`define PHSC_CLASS_SUB      8'h80
`define PHSC_CLASS_PROG     8'h00

`define PHSC_WIN_LSB        12
`define PHSC_LT_LSB         11
`define PHSC_LT_MSB         15
`define PHSC_SC_TYPE_LSB    0
`define PHSC_SC_LAS_POS     2

`define PHSC_SC_DISABLE     2'h0
`define PHSC_SC_RMW         2'h1
`define PHSC_SC_LOCK        2'h2
`define PHSC_SC_RSVD        2'h3

`define PHSC_RST_BASE       20'h00000
`define PHSC_RST_LT         5'h00
`define PHSC_RST_SC_TYPE    2'h0
`define PHSC_RST_SC_ADDR    32'h00000000
`define PHSC_SPACE_MEM      1'b0
`define PHSC_SPACE_IO       1'b1

`endif

//--- core/phsc_pkg.sv
// Types shared by the header and special cycle register bank.
`default_nettype none

package phsc_pkg;

    typedef struct packed {
        logic        valid;
        logic        write;
        logic        cfg;
        logic        vme;
        logic        io;
        logic [31:0] addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } phsc_req_type;

    typedef struct packed {
        logic        ack;
        logic        hit;
        logic [31:0] rdata;
    } phsc_rsp_type;

    typedef struct packed {
        logic        start;
        logic        lock;
        logic        read_modify_write;
        logic        write;
        logic [31:0] addr;
    } phsc_special_cycle_type_type;

    typedef struct packed {
        logic          strap_taken;
        logic          space;
        logic [19:0]   base_pri;
        logic [19:0]   base_alt;
        logic          pri_written;
        logic          alt_written;
        logic [4:0]    lat_timer;
        logic [1:0]    sc_type;
        logic          sc_las;
        logic [31:0]   sc_addr;
        phsc_rsp_type  rsp;
        phsc_special_cycle_type_type special_cycle_type;
    } phsc_state_type;

endpackage

`default_nettype wire

//--- core/phsc_regs.sv
// Configuration header, register window decode and special cycle generator control.
// Functional notes
// RQ1: Primary base holds writable bits 31..12, reset zero, 4 KB aligned window.
// RQ2: Bit 0 of each base is read-only; the primary base reports the strapped space, the alternate base the opposite space.
// RQ3: Memory window may sit anywhere in 32 bits and is not prefetchable.
// RQ4: Alternate base always maps the window into the opposite space.
// RQ5: A base decodes nothing until it has been written by config or VME.
// RQ6: Multifunction reads zero; address bits 10..8 ignored on type 0 config.
// RQ7: Not self-test capable; capability, start and completion fields read zero, writes ignored.
// RQ8: Latency timer writable in bits 7..3 only, low bits zero, reset zero.
// RQ9: Class register gives read-only revision byte plus class bytes.
// RQ10: Two-bit cycle type: off, read-modify-write, locked, reserved; reset zero.
// RQ11: Space-select bit chooses memory or I/O match for the target address.
// RQ12: Enabled generator starts its cycle when an access hits the target.
// RQ13: Read-modify-write starts only on a read of the target address.
// RQ14: Locked cycle starts on a read or a write of the target address.
// RQ15: Writes to fixed bits are ignored and reads return fixed values.
`default_nettype none

`include "phsc_map.svh"

module phsc_regs
    import phsc_pkg::*;
#(
    parameter logic [7:0] REV_ID = 8'h0A  // Arbitrary value.
) (
    input  wire logic    clock,
    input  wire logic    rstn,
    input  wire logic    space_strap,
    input  wire phsc_req_type  req,
    output var  phsc_rsp_type  rsp,
    output var  phsc_special_cycle_type_type special_cycle_type
);

    phsc_state_type st_r;
    phsc_state_type st_nxt;
    logic [31:0]    bmask;
    logic [31:0]    merged;
    logic [11:0]    off;
    logic           hit_pri;
    logic           hit_alt;
    logic           reg_sel;
    logic           sc_match;
    logic [31:0]    rd_val;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_lane
            assign bmask[8*gi +: 8] = {8{req.be[gi]}};
        end
    endgenerate

    // Old contents survive in lanes whose enable is low.
    function automatic logic [31:0] merge_lanes(input logic [31:0] old_v);
        merge_lanes = (old_v & ~bmask) | (req.wdata & bmask);
    endfunction

    always_comb begin
        // Config space is 256 bytes and only bits 7..2 name the word.
        if (req.cfg) begin
            off = {4'h0, req.addr[7:2], 2'b00};  // see RQ6
        end else begin
            off = {req.addr[11:2], 2'b00};
        end
        // A base that was never written claims nothing, so a zero reset
        // value cannot alias the window onto address zero.
        hit_pri = st_r.strap_taken && st_r.pri_written
                  && (req.io == st_r.space)
                  && (req.addr[31:`PHSC_WIN_LSB] == st_r.base_pri);  // see RQ5
        hit_alt = st_r.strap_taken && st_r.alt_written
                  && (req.io != st_r.space)
                  && (req.addr[31:`PHSC_WIN_LSB] == st_r.base_alt);  // see RQ4
        reg_sel = req.cfg || req.vme || hit_pri || hit_alt;
        sc_match = !req.cfg && !req.vme
                   && (req.io == st_r.sc_las)                         // see RQ11
                   && (req.addr == st_r.sc_addr);                     // see RQ12
    end

    always_comb begin
        unique case (off)
            `PHSC_OFF_CLASS: begin
                rd_val = {`PHSC_CLASS_BASE, `PHSC_CLASS_SUB,
                          `PHSC_CLASS_PROG, REV_ID};                  // see RQ9
            end
            `PHSC_OFF_INFO: begin
                rd_val = {16'h0000, st_r.lat_timer, 3'b000, 8'h00};   // see RQ7
            end
            `PHSC_OFF_BASE_PRI: begin
                rd_val = {st_r.base_pri, 11'h000, st_r.space};        // see RQ3
            end
            `PHSC_OFF_BASE_ALT: begin
                rd_val = {st_r.base_alt, 11'h000,
                          st_r.strap_taken & ~st_r.space};            // see RQ2
            end
            `PHSC_OFF_SC_CTL: begin
                rd_val = {29'h0000000, st_r.sc_las, st_r.sc_type};
            end
            `PHSC_OFF_SC_ADDR: begin
                rd_val = st_r.sc_addr;
            end
            default: begin
                rd_val = 32'h00000000;
            end
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        merged = merge_lanes(rd_val);
        st_nxt.rsp.ack = 1'b0;
        st_nxt.special_cycle_type.start = 1'b0;
        // The strap is caught on the first edge after reset, never by the reset itself.
        if (!st_r.strap_taken) begin
            st_nxt.strap_taken = 1'b1;
            st_nxt.space = space_strap;                               // see RQ2
        end
        if (req.valid) begin
            st_nxt.rsp.ack = 1'b1;
            st_nxt.rsp.hit = reg_sel;
            st_nxt.rsp.rdata = (reg_sel && !req.write) ? rd_val : 32'h00000000;
            if (reg_sel && req.write) begin
                unique case (off)
                    `PHSC_OFF_INFO: begin
                        st_nxt.lat_timer =
                            merged[`PHSC_LT_MSB:`PHSC_LT_LSB];        // see RQ8
                    end
                    `PHSC_OFF_BASE_PRI: begin
                        st_nxt.base_pri = merged[31:`PHSC_WIN_LSB];  // see RQ1
                        st_nxt.pri_written = 1'b1;                   // see RQ5
                    end
                    `PHSC_OFF_BASE_ALT: begin
                        st_nxt.base_alt = merged[31:`PHSC_WIN_LSB];
                        st_nxt.alt_written = 1'b1;                   // see RQ5
                    end
                    `PHSC_OFF_SC_CTL: begin
                        st_nxt.sc_type = merged[1:0];                // see RQ10
                        st_nxt.sc_las = merged[`PHSC_SC_LAS_POS];    // see RQ11
                    end
                    `PHSC_OFF_SC_ADDR: begin
                        st_nxt.sc_addr = merged;
                    end
                    default: begin
                        // Read-only and fixed words keep their values.  see RQ15
                    end
                endcase
            end
            if (sc_match) begin
                unique case (st_r.sc_type)
                    `PHSC_SC_RMW: begin
                        st_nxt.special_cycle_type.start = !req.write;              // see RQ13
                    end
                    `PHSC_SC_LOCK: begin
                        st_nxt.special_cycle_type.start = 1'b1;                    // see RQ14
                    end
                    default: begin
                        // Disabled and reserved codes start nothing.  see RQ10
                        st_nxt.special_cycle_type.start = 1'b0;
                    end
                endcase
                st_nxt.special_cycle_type.lock = (st_r.sc_type == `PHSC_SC_LOCK);
                st_nxt.special_cycle_type.read_modify_write = (st_r.sc_type == `PHSC_SC_RMW);
                st_nxt.special_cycle_type.write = req.write;
                st_nxt.special_cycle_type.addr = req.addr;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_r <= '0;
            st_r.base_pri <= `PHSC_RST_BASE;
            st_r.base_alt <= `PHSC_RST_BASE;
            st_r.lat_timer <= `PHSC_RST_LT;
            st_r.sc_type <= `PHSC_RST_SC_TYPE;
            st_r.sc_addr <= `PHSC_RST_SC_ADDR;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rsp = st_r.rsp;
    assign special_cycle_type = st_r.special_cycle_type;

endmodule

`default_nettype wire

//--- testbench/phsc_check_assertions.sv
// Port checker for the header and special cycle register bank.
`default_nettype none
module phsc_check
    import phsc_pkg::*;
(
    input wire logic          clock,
    input wire logic          rstn,
    input wire logic          space_strap,
    input wire phsc_req_type  req,
    input wire phsc_rsp_type  rsp,
    input wire phsc_special_cycle_type_type special_cycle_type
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    cycle_kind_a: assert property (special_cycle_type.start |-> rsp.ack && (special_cycle_type.lock ^ special_cycle_type.read_modify_write))
        else $error("start without ack or with a bad kind");
    rmw_read_a: assert property (special_cycle_type.start && special_cycle_type.read_modify_write |-> !$past(req.write))
        else $error("read-modify-write opened by a write");
    lock_dir_a: assert property (special_cycle_type.start && special_cycle_type.lock |-> special_cycle_type.write == $past(req.write))
        else $error("locked cycle direction differs");
    start_addr_a: assert property (special_cycle_type.start |-> special_cycle_type.addr == $past(req.addr))
        else $error("start address differs");
    cfg_claim_a: assert property (req.valid && req.cfg |=> rsp.ack && rsp.hit)
        else $error("config access not claimed");
    miss_zero_a: assert property (rsp.ack && !rsp.hit |-> rsp.rdata == 32'h0)
        else $error("unclaimed access returned data");
    info_fixed_a: assert property (
        req.valid && req.cfg && !req.write && req.addr[7:2] == 6'h03
        |=> (rsp.rdata & 32'hFFFF07FF) == 32'h0) else $error("fixed header bits set");
    class_fixed_a: assert property (
        req.valid && req.cfg && !req.write && req.addr[7:2] == 6'h02
        |=> rsp.rdata[31:8] == 24'h068000) else $error("class bytes wrong");
    base_space_a: assert property (
        req.valid && req.cfg && !req.write && req.addr[7:2] == 6'h04
        && $past(rstn) |=> rsp.rdata[11:0] == {11'h0, space_strap})
        else $error("base space bit wrong");
endmodule
bind phsc_regs phsc_check u_check (.clock(clock), .rstn(rstn), .space_strap(space_strap),
    .req(req), .rsp(rsp), .special_cycle_type(special_cycle_type));
`default_nettype wire

//--- testbench/phsc_host.sv
// Host model that issues one request a clock.
`default_nettype none
module phsc_host
    import phsc_pkg::*;
(
    input  wire logic       clock,
    output var phsc_req_type req
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    // Callers write a base before relying on its window, apart from one probe of an unwritten base that expects a miss, and open read-modify-write with a read.
    task automatic acc(input logic [2:0] k, input logic wr, input logic [31:0] a, d);
        @(negedge clock);
        req = '{1'b1, wr, k[2], k[1], k[0], a, 4'hF, d};
    endtask
    // Released address and data lines are inverted so a stale value can never look valid.
    task automatic idle();
        @(negedge clock);
        req.valid = 1'b0;
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask
endmodule
`default_nettype wire

//--- testbench/phsc_regs_bench.sv
// Self-checking bench for the header and special cycle register bank.
`default_nettype none
module phsc_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import phsc_pkg::*;
    localparam logic [2:0] CFG = 3'h4, VME = 3'h2, RD = 3'h2, WR = 3'h6;
    logic          clock = 1'b0;
    logic          rstn = 1'b0;
    logic          strap = 1'b0;
    logic          st;
    logic [1:0]    ty;
    logic [31:0]   r, ta;
    logic [35:0]   expq[$];
    int            num_errors = 0;
    int            comparisons = 0;
    phsc_req_type  req;
    phsc_rsp_type  rsp;
    phsc_special_cycle_type_type special_cycle_type;
    always #50 clock = ~clock;
    phsc_host host (.clock(clock), .req(req));
    phsc_regs #(.REV_ID(8'h3C)) DUT (.clock(clock), .rstn(rstn), .space_strap(strap),
        .req(req), .rsp(rsp), .special_cycle_type(special_cycle_type));
    task automatic check(input logic [35:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Flags are {write, hit, start}; the lock and rmw bits follow the cycle type in force.
    task automatic go(input logic [2:0] k, f, input logic [31:0] a, d, e);
        expq.push_back({f[1], f[0], f[0] & (ty == 2'h2), f[0] & (ty == 2'h1), e});
        host.acc(k, f[2], a, d);
    endtask
    always @(negedge clock) begin
        if (rsp.ack === 1'b1) begin
            if (expq.size() == 0) begin
                check(36'h1, 36'h0);
            end else begin
                check({rsp.hit, special_cycle_type.start, special_cycle_type.start & special_cycle_type.lock, special_cycle_type.start & special_cycle_type.read_modify_write,
                    rsp.rdata}, expq.pop_front());
            end
        end
    end
    initial begin
        void'($urandom(32'h5E12));
        for (int s = 0; s < 2; s++) begin
            strap = s[0];
            rstn = 1'b0;
            ty = 2'h0;
            repeat (2) @(negedge clock);
            rstn = 1'b1;
            @(negedge clock);
            go(CFG, RD, 32'h708, 32'h0, 32'h0680003C);
            go(CFG, RD, 32'h10, 32'h0, {31'h0, strap});
            go(CFG, RD, 32'h14, 32'h0, {31'h0, ~strap});
            go({2'h0, strap}, 3'h0, 32'h170, 32'h0, 32'h0);
            go(CFG, WR, 32'h0C, 32'hFFFFFFFF, 32'h0);
            go(CFG, RD, 32'h0C, 32'h0, 32'h0000F800);
            go(CFG, WR, 32'h08, 32'hFFFFFFFF, 32'h0);
            go(CFG, RD, 32'h08, 32'h0, 32'h0680003C);
            r = $urandom;
            ta = $urandom;
            go(CFG, WR, 32'h10, r, 32'h0);
            go(CFG, RD, 32'h10, 32'h0, {r[31:12], 11'h0, strap});
            go(VME, WR, 32'h174, ta, 32'h0);
            go(VME, RD, 32'h194, 32'h0, 32'h0);
            go(CFG, WR, 32'h14, ~r, 32'h0);
            go({2'h0, ~strap}, RD, {~r[31:12], 12'h174}, 32'h0, ta);
            for (int t = 0; t < 8; t++) begin
                ty = t[1:0];
                go(VME, WR, 32'h170, {29'h0, t[2:0]}, 32'h0);
                go({2'h0, strap}, RD, {r[31:12], 12'h170}, 32'h0, {29'h0, t[2:0]});
                for (int k = 0; k < 4; k++) begin
                    st = (k[0] == t[2]) && (ty == 2'h2 || (ty == 2'h1 && !k[1]));
                    go({2'h0, k[0]}, {k[1], 1'b0, st}, ta, r, 32'h0);
                end
            end
            host.idle();
        end
        repeat (3) @(negedge clock);
        check(36'(expq.size()), 36'h0);
        report_and_stop();
    end
endmodule
`default_nettype wire
